// File: design/tie_map.svh
// Constants for the trace item encoder: item layout, tags, codes
`ifndef TIE_MAP_SVH
`define TIE_MAP_SVH

`define TIE_ITEM_W 18
`define TIE_TAG_BRANCH 2'h0
`define TIE_TAG_PC 2'h1
`define TIE_TAG_DATA 2'h2
`define TIE_TAG_EVENT 2'h3
`define TIE_EV_INSTR 2'h0
`define TIE_EV_TSTAMP 2'h1
`define TIE_EV_XTRIG 2'h2
`define TIE_EV_EXC 2'h3
`define TIE_CC_ONE 2'h1
`define TIE_CC_TWO 2'h2
`define TIE_CC_LONG 2'h3
`define TIE_BR_MAX_CNT 4'hc
`define TIE_SHORT_MAX 13'h003f
`define TIE_LONG_MAX 13'h1fff
`define TIE_TS_MAX 14'h3fff
`define TIE_EXC_DEBUG 5'h09
`define TIE_EXC_IRQ 5'h0a
`define TIE_EXC_NMBRK 5'h0b
`define TIE_EXC_BRK 5'h0c
`define TIE_ADDR_SIZE_DEF 64
`define TIE_ADDR_THREE_MAX 48

`endif

// File: design/tie_pkg.sv
// Types shared by the trace item encoder and its bench
package tie_pkg;
    typedef enum logic [3:0] {
        TIE_K_PC = 4'h0,
        TIE_K_DATA32 = 4'h1,
        TIE_K_DATA64 = 4'h2,
        TIE_K_SWEVT = 4'h3,
        TIE_K_XTRIG = 4'h4,
        TIE_K_EXC = 4'h5,
        TIE_K_TSTAMP = 4'h6,
        TIE_K_BRANCH = 4'h7,
        TIE_K_CCBR = 4'h8,
        TIE_K_FLUSH = 4'h9
    } tie_kind_e;
    typedef logic [17:0] tie_item_t;
endpackage

// File: design/tie_encoder.sv
// Trace item encoder: requests in, 18-bit trace items out via two-entry buffer
`include "tie_map.svh"

module tie_encoder #(
    parameter int ADDR_SIZE = `TIE_ADDR_SIZE_DEF
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Request from the pipeline
    input wire logic req_valid,
    output logic req_ready,
    input wire tie_pkg::tie_kind_e req_kind,
    input wire logic [63:0] req_data,
    // Item stream to the trace buffer
    output logic item_valid,
    input wire logic item_ready,
    output tie_pkg::tie_item_t item_data
);
    import tie_pkg::*;

    // Serializer state
    tie_item_t ser_item_reg [0:4];
    logic [2:0] ser_cnt_reg;
    logic [2:0] ser_pos_reg;
    // Pending first short cycle-count branch
    logic pend_reg;
    logic [5:0] pend_cnt_reg;
    logic pend_tk_reg;
    // Counters
    logic [12:0] cyc_reg;
    logic [13:0] ts_reg;
    // Output buffer
    tie_item_t head_reg;
    tie_item_t tail_reg;
    logic [1:0] fcnt_reg;
    logic head_vld_reg;
    logic ready_reg;

    // Decode results
    tie_item_t ld_item [0:3];
    logic [2:0] ld_n;
    logic take;
    logic pend_set;
    logic pend_clr;
    logic [63:0] pc_z;
    tie_item_t pend_item;
    tie_item_t ccbr_item;
    tie_item_t evt_item;
    logic short_br;
    logic [3:0] br_n;
    logic idle;
    logic push;
    logic pop;
    tie_item_t push_item;
    // Serializer load: request items, led by a flushed held branch
    tie_item_t sl_item [0:4];
    logic [2:0] sl_n;

    assign idle = (ser_pos_reg == ser_cnt_reg);
    assign short_br = (cyc_reg <= `TIE_SHORT_MAX);
    assign br_n = (req_data[15:12] > `TIE_BR_MAX_CNT) ? `TIE_BR_MAX_CNT : req_data[15:12];
    assign pend_item = {`TIE_TAG_BRANCH, `TIE_CC_ONE, pend_cnt_reg, pend_tk_reg, 7'h00};

    // Address bits above the configured width are forced to zero
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi++)
        begin : g_pc
            assign pc_z[gi] = (gi < ADDR_SIZE) ? req_data[gi] : 1'b0;
        end
    endgenerate

    // Event item by kind
    always_comb
    begin
        evt_item = {`TIE_TAG_EVENT, `TIE_EV_INSTR, req_data[13:0]};
        unique case (req_kind)
            // reserved bits zero, one bit per trigger
            TIE_K_XTRIG: evt_item = {`TIE_TAG_EVENT, `TIE_EV_XTRIG, 6'h00, req_data[7:0]};
            TIE_K_EXC: evt_item = {`TIE_TAG_EVENT, `TIE_EV_EXC, 9'h000, req_data[4:0]};
            TIE_K_TSTAMP: evt_item = {`TIE_TAG_EVENT, `TIE_EV_TSTAMP, ts_reg};
            default: evt_item = {`TIE_TAG_EVENT, `TIE_EV_INSTR, req_data[13:0]};
        endcase
    end

    // Cycle-count branch item
    always_comb
    begin
        ccbr_item = {`TIE_TAG_BRANCH, `TIE_CC_LONG, cyc_reg, req_data[0]};
        if (short_br && pend_reg)
        begin
            // two short branches in one item
            ccbr_item = {`TIE_TAG_BRANCH, `TIE_CC_TWO, pend_cnt_reg, pend_tk_reg, cyc_reg[5:0], req_data[0]};
        end
    end

    // Request decode into up to four items
    always_comb
    begin
        take = 1'b0;
        ld_n = 3'h0;
        pend_set = 1'b0;
        pend_clr = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            ld_item[i] = '0;
        end
        if (idle && req_valid)
        begin
            // Ready promised a take in every cycle but the first after reset, so every request is taken here
            take = 1'b1;
            pend_clr = pend_reg && (req_kind != TIE_K_CCBR);
            // Flush has no items of its own
            if (req_kind != TIE_K_FLUSH)
            begin
                unique case (req_kind)
                    TIE_K_PC:
                    begin
                        if (ADDR_SIZE <= `TIE_ADDR_THREE_MAX)
                        begin
                            ld_n = 3'h3;
                            ld_item[0] = {`TIE_TAG_PC, pc_z[47:32]};
                            ld_item[1] = {`TIE_TAG_PC, pc_z[31:16]};
                            ld_item[2] = {`TIE_TAG_PC, pc_z[15:0]};
                        end
                        else
                        begin
                            ld_n = 3'h4;
                            ld_item[0] = {`TIE_TAG_PC, pc_z[63:48]};
                            ld_item[1] = {`TIE_TAG_PC, pc_z[47:32]};
                            ld_item[2] = {`TIE_TAG_PC, pc_z[31:16]};
                            ld_item[3] = {`TIE_TAG_PC, pc_z[15:0]};
                        end
                    end
                    TIE_K_DATA32:
                    begin
                        ld_n = 3'h2;
                        ld_item[0] = {`TIE_TAG_DATA, req_data[31:16]};
                        ld_item[1] = {`TIE_TAG_DATA, req_data[15:0]};
                    end
                    TIE_K_DATA64:
                    begin
                        ld_n = 3'h4;
                        ld_item[0] = {`TIE_TAG_DATA, req_data[63:48]};
                        ld_item[1] = {`TIE_TAG_DATA, req_data[47:32]};
                        ld_item[2] = {`TIE_TAG_DATA, req_data[31:16]};
                        ld_item[3] = {`TIE_TAG_DATA, req_data[15:0]};
                    end
                    TIE_K_SWEVT, TIE_K_XTRIG, TIE_K_EXC, TIE_K_TSTAMP:
                    begin
                        ld_n = 3'h1;
                        ld_item[0] = evt_item;
                    end
                    TIE_K_BRANCH:
                    begin
                        ld_n = 3'h1;
                        ld_item[0] = {`TIE_TAG_BRANCH, br_n, req_data[11:0]};
                    end
                    TIE_K_CCBR:
                    begin
                        if (short_br && !pend_reg)
                        begin
                            // Hold first short branch hoping to pair it
                            pend_set = 1'b1;
                        end
                        else if (!short_br && pend_reg)
                        begin
                            ld_n = 3'h2;
                            ld_item[0] = pend_item;
                            ld_item[1] = ccbr_item;
                            pend_clr = 1'b1;
                        end
                        else
                        begin
                            ld_n = 3'h1;
                            ld_item[0] = ccbr_item;
                            pend_clr = 1'b1;
                        end
                    end
                    default:
                    begin
                        // Encodings outside the kind enum emit nothing
                        ld_n = 3'h0;
                    end
                endcase
            end
        end
    end

    // Held lone branch goes out first, so the request that flushes it is never lost
    always_comb
    begin
        sl_n = ld_n;
        sl_item[0] = ld_item[0];
        sl_item[1] = ld_item[1];
        sl_item[2] = ld_item[2];
        sl_item[3] = ld_item[3];
        sl_item[4] = '0;
        if (pend_clr && req_kind != TIE_K_CCBR)
        begin
            sl_n = ld_n + 3'h1;
            sl_item[0] = pend_item;
            sl_item[1] = ld_item[0];
            sl_item[2] = ld_item[1];
            sl_item[3] = ld_item[2];
            sl_item[4] = ld_item[3];
        end
    end

    // Serializer load and advance
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ser_cnt_reg <= 3'h0;
            ser_pos_reg <= 3'h0;
            for (int i = 0; i < 5; i++)
            begin
                ser_item_reg[i] <= '0;
            end
        end
        else if (sl_n != 3'h0)
        begin
            ser_cnt_reg <= sl_n;
            ser_pos_reg <= 3'h0;
            for (int i = 0; i < 5; i++)
            begin
                ser_item_reg[i] <= sl_item[i];
            end
        end
        else if (push)
        begin
            ser_pos_reg <= ser_pos_reg + 3'h1;
        end
    end

    // Pending short branch
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_reg <= 1'b0;
            pend_cnt_reg <= 6'h00;
            pend_tk_reg <= 1'b0;
        end
        else if (pend_set)
        begin
            pend_reg <= 1'b1;
            pend_cnt_reg <= cyc_reg[5:0];
            pend_tk_reg <= req_data[0];
        end
        else if (pend_clr)
        begin
            pend_reg <= 1'b0;
        end
    end

    // Cycle and time-stamp counters, saturating so a stall never wraps them
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cyc_reg <= 13'h0000;
            ts_reg <= 14'h0000;
        end
        else
        begin
            if (take && req_kind == TIE_K_CCBR)
            begin
                cyc_reg <= 13'h0000;
            end
            else if (cyc_reg != `TIE_LONG_MAX)
            begin
                cyc_reg <= cyc_reg + 13'h0001;
            end
            if (take && req_kind == TIE_K_TSTAMP)
            begin
                ts_reg <= 14'h0000;
            end
            else if (ts_reg != `TIE_TS_MAX)
            begin
                ts_reg <= ts_reg + 14'h0001;
            end
        end
    end

    // Request ready: registered, high only when the serializer is empty
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ready_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= (sl_n == 3'h0) && ((ser_pos_reg + {2'h0, push}) == ser_cnt_reg) && !pend_clr;
        end
    end
    assign req_ready = ready_reg;

    // Two-entry output buffer; head drives the port directly
    assign push = !idle && (fcnt_reg != 2'h2);
    assign pop = head_vld_reg && item_ready;
    // Position stays below the count, at most five, whenever push is high
    assign push_item = ser_item_reg[ser_pos_reg];

    // each entry holds one whole 18-bit item
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            head_reg <= '0;
            tail_reg <= '0;
            fcnt_reg <= 2'h0;
            head_vld_reg <= 1'b0;
        end
        else
        begin
            if (push && !pop)
            begin
                if (fcnt_reg == 2'h0)
                begin
                    head_reg <= push_item;
                end
                else
                begin
                    tail_reg <= push_item;
                end
                fcnt_reg <= fcnt_reg + 2'h1;
                head_vld_reg <= 1'b1;
            end
            else if (pop && !push)
            begin
                head_reg <= tail_reg;
                fcnt_reg <= fcnt_reg - 2'h1;
                head_vld_reg <= (fcnt_reg == 2'h2);
            end
            else if (push && pop)
            begin
                if (fcnt_reg == 2'h1)
                begin
                    head_reg <= push_item;
                end
                else
                begin
                    head_reg <= tail_reg;
                    tail_reg <= push_item;
                end
            end
        end
    end
    assign item_valid = head_vld_reg;
    assign item_data = head_reg;
endmodule

// File: sim/tie_sink.sv
// Trace buffer model that takes items and stalls in bursts on request
module tie_sink (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Stall request from the bench
    input wire logic stall,
    // Item stream
    input wire logic item_valid,
    output logic item_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    // Ready moves on the falling edge, clear of the sampling edge
    always @(negedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase <= 2'h0;
            item_ready <= 1'b0;
        end
        else
        begin
            // Count offered cycles only, so every burst sees the same refusals
            phase <= phase + {1'b0, item_valid};
            // Refuse three cycles in four so the buffer really fills
            item_ready <= !stall || (phase == 2'h3);
        end
    end
endmodule

// File: sim/tie_encoder_properties.sv
// Port checks for the trace item encoder
module tie_checker import tie_pkg::*; #(
    parameter int ADDR_SIZE = 64
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire tie_pkg::tie_kind_e req_kind,
    input wire logic [63:0] req_data,
    // Item side
    input wire logic item_valid,
    input wire logic item_ready,
    input wire tie_pkg::tie_item_t item_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] data_reg;
    logic [63:0] pc_m;
    logic take;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Only an empty buffer gives a fixed two-cycle answer
    assign take = req_valid && req_ready && !item_valid;
    // Shift by 64 wraps to zero, so a full width keeps all bits
    assign pc_m = data_reg & ((64'h1 << ADDR_SIZE) - 64'h1);
    // Payload of the last request taken; the first item shows two edges later
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            data_reg <= 64'h0;
        else if (take)
            data_reg <= req_data;
    end
    AST_ITEM_HOLD: assert property (item_valid && !item_ready |=> item_valid && $stable(item_data))
        else $error("item changed while stalled");
    AST_PC_FIRST: assert property (take && req_kind == TIE_K_PC |-> ##2
        item_valid && item_data == {2'h1, (ADDR_SIZE > 48 ? pc_m[63:48] : pc_m[47:32])})
        else $error("wrong first address item");
    AST_DATA32_FIRST: assert property (take && req_kind == TIE_K_DATA32 |-> ##2
        item_data == {2'h2, data_reg[31:16]})
        else $error("wrong first data item");
    AST_DATA32_BUSY: assert property (take && req_kind == TIE_K_DATA32 |=> !req_ready [*2])
        else $error("request accepted during data items");
    AST_DATA64_FIRST: assert property (take && req_kind == TIE_K_DATA64 |-> ##2
        item_data == {2'h2, data_reg[63:48]})
        else $error("wrong first long data item");
    AST_SWEVT: assert property (take && req_kind == TIE_K_SWEVT |-> ##2
        item_data == {4'hc, data_reg[13:0]})
        else $error("wrong software event item");
    AST_XTRIG: assert property (take && req_kind == TIE_K_XTRIG |-> ##2
        item_data == {4'he, 6'h0, data_reg[7:0]})
        else $error("wrong cross trigger item");
    AST_EXC: assert property (take && req_kind == TIE_K_EXC |-> ##2
        item_data == {4'hf, 9'h0, data_reg[4:0]})
        else $error("wrong exception item");
    AST_BRANCH: assert property (take && req_kind == TIE_K_BRANCH && req_data[15:12] <= 4'hc |-> ##2
        item_valid && item_data == {2'h0, data_reg[15:0]})
        else $error("wrong branch item");
    AST_EV_TAG: assert property (take && req_kind == TIE_K_TSTAMP |-> ##2 item_data[17:14] == 4'hd)
        else $error("wrong time stamp tag");
endmodule

bind tie_encoder tie_checker #(.ADDR_SIZE(ADDR_SIZE)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_data(req_data),
    .item_valid(item_valid), .item_ready(item_ready), .item_data(item_data));

// File: sim/test_trace_item_encoder.sv
// Self-checking bench for the trace item encoder
module test_trace_item_encoder import tie_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic arst_n;
    logic req_valid;
    logic req_ready;
    tie_kind_e req_kind;
    logic [63:0] req_data;
    logic item_valid;
    logic item_ready;
    logic stall;
    tie_item_t item_data;
    tie_item_t exp_q[$];
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t_take;
    int t_prev;
    int c1;

    tie_encoder #(.ADDR_SIZE(64)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_kind(req_kind), .req_data(req_data), .item_valid(item_valid),
        .item_ready(item_ready), .item_data(item_data));
    tie_sink u_sink (.clk_sys(clk_sys), .arst_n(arst_n), .stall(stall), .item_valid(item_valid),
        .item_ready(item_ready));

    // Clock and edge count
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    // Every item the sink takes must be the next one expected
    always @(posedge clk_sys)
    begin
        if (item_valid === 1'b1 && item_ready === 1'b1)
        begin
            cmp_count++;
            if (exp_q.size() == 0 || item_data !== exp_q[0])
            begin
                n_errors++;
                $display("unexpected item_data: expected %h seen %h", exp_q.size() ? exp_q[0] : 18'h0, item_data);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    // One request, held until the edge that takes it
    task automatic send(input tie_kind_e k, input logic [63:0] d);
        int n;
        n = 0;
        req_kind = k;
        req_data = d;
        req_valid = 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (req_ready !== 1'b1 && n < 300);
        if (n >= 300)
        begin
            n_errors++;
            $display("unexpected req_ready: expected 1 seen %b", req_ready);
        end
        t_take = cyc;
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask

    task automatic t_pc();
        exp_q = {18'h10123, 18'h14567, 18'h189ab, 18'h1cdef};
        send(TIE_K_PC, 64'h0123456789abcdef);
        $display("done pc");
    endtask

    // Long data under a stalling sink, so the buffer fills
    task automatic t_data();
        exp_q.push_back(18'h21234);
        exp_q.push_back(18'h25678);
        send(TIE_K_DATA32, 64'hffffffff12345678);
        stall = 1'b1;
        exp_q.push_back(18'h2fedc);
        exp_q.push_back(18'h2ba98);
        exp_q.push_back(18'h27654);
        exp_q.push_back(18'h23210);
        send(TIE_K_DATA64, 64'hfedcba9876543210);
        repeat (40) @(negedge clk_sys);
        stall = 1'b0;
        $display("done data");
    endtask

    // Upper payload bits set to catch leaks into reserved fields
    task automatic t_events();
        logic [4:0] codes[4];
        codes = '{5'h09, 5'h0a, 5'h0b, 5'h0c};
        exp_q.push_back({4'hc, 14'h2abc});
        send(TIE_K_SWEVT, 64'hffffffffffffeabc);
        exp_q.push_back({4'he, 6'h0, 8'h05});
        send(TIE_K_XTRIG, 64'hffffffffffffff05);
        foreach (codes[i])
        begin
            exp_q.push_back({4'hf, 9'h0, codes[i]});
            send(TIE_K_EXC, {59'h7fffffffffffff0, codes[i]});
        end
        $display("done events");
    endtask

    task automatic t_branch();
        exp_q.push_back({2'h0, 16'hca5f});
        send(TIE_K_BRANCH, 64'hca5f);
        exp_q.push_back(18'h0);
        send(TIE_K_BRANCH, 64'h0);
        $display("done branch");
    endtask

    // First stamp after a long idle saturates
    task automatic t_tstamp();
        repeat (16400) @(negedge clk_sys);
        exp_q.push_back({4'hd, 14'h3fff});
        send(TIE_K_TSTAMP, 64'h0);
        t_prev = t_take;
        repeat (9) @(negedge clk_sys);
        send(TIE_K_TSTAMP, 64'h0);
        exp_q.push_back({4'hd, 14'(t_take - t_prev - 1)});
        $display("done tstamp");
    endtask

    // Long count, then a short pair, then a lone short flushed
    task automatic t_ccbr();
        exp_q.push_back({4'h3, 13'h1fff, 1'b1});
        send(TIE_K_CCBR, 64'h1);
        t_prev = t_take;
        repeat (5) @(negedge clk_sys);
        send(TIE_K_CCBR, 64'h0);
        // The take edge itself is not counted
        c1 = t_take - t_prev - 1;
        t_prev = t_take;
        repeat (7) @(negedge clk_sys);
        send(TIE_K_CCBR, 64'h1);
        exp_q.push_back({4'h2, 6'(c1), 1'b0, 6'(t_take - t_prev - 1), 1'b1});
        t_prev = t_take;
        repeat (3) @(negedge clk_sys);
        send(TIE_K_CCBR, 64'h1);
        exp_q.push_back({4'h1, 6'(t_take - t_prev - 1), 1'b1, 7'h0});
        send(TIE_K_FLUSH, 64'h0);
        repeat (10) @(negedge clk_sys);
        $display("done ccbr");
    endtask

    task automatic tally_and_finish();
        if (exp_q.size() != 0)
        begin
            n_errors++;
            $display("unexpected items left: expected 0 seen %0d", exp_q.size());
        end
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_kind = TIE_K_FLUSH;
        req_data = 64'h0;
        stall = 1'b0;
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        t_pc();
        t_data();
        t_events();
        t_branch();
        t_tstamp();
        t_ccbr();
        tally_and_finish();
    end

    // Watchdog well past the expected run of some 17000 cycles
    initial
    begin
        #200000;
        n_errors++;
        $display("unexpected watchdog: expected end of tests seen timeout");
        tally_and_finish();
    end
endmodule
